/* File: design/timer2_pkg.sv */
package timer2_pkg;

  // register offsets on the i/o port
  localparam logic [5:0] COMPARE_VALUE_ADDR = 6'h23;
  localparam logic [5:0] COUNTER_VALUE_ADDR = 6'h24;
  localparam logic [5:0] TIMER_CONTROL_ADDR = 6'h25;

  // timer_control_reg field positions
  localparam int FORCE_COMPARE_BIT = 7;
  localparam int WAVE_MODE_LOW_BIT = 6;
  localparam int OUT_MODE_HIGH_BIT = 5;
  localparam int OUT_MODE_LOW_BIT = 4;
  localparam int WAVE_MODE_HIGH_BIT = 3;
  localparam int CLOCK_SELECT_MSB = 2;
  localparam int CLOCK_SELECT_LSB = 0;

  // reset values
  localparam logic [7:0] TIMER_CONTROL_RESET = 8'h00;
  localparam logic [7:0] COUNTER_VALUE_RESET = 8'h00;
  localparam logic [7:0] COMPARE_VALUE_RESET = 8'h00;

  // counter limits
  localparam logic [7:0] COUNT_MAX = 8'hff;
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;

  // prescaler: divide ratios as powers of two
  localparam int PRESCALE_WIDTH = 10;
  localparam int DIV8_LOG2 = 3;
  localparam int DIV32_LOG2 = 5;
  localparam int DIV64_LOG2 = 6;
  localparam int DIV128_LOG2 = 7;
  localparam int DIV256_LOG2 = 8;
  localparam int DIV1024_LOG2 = 10;

  localparam logic [2:0] CLOCK_STOPPED = 3'h0;
  localparam logic [2:0] CLOCK_DIV1 = 3'h1;
  localparam logic [2:0] CLOCK_DIV8 = 3'h2;
  localparam logic [2:0] CLOCK_DIV32 = 3'h3;
  localparam logic [2:0] CLOCK_DIV64 = 3'h4;
  localparam logic [2:0] CLOCK_DIV128 = 3'h5;
  localparam logic [2:0] CLOCK_DIV256 = 3'h6;
  localparam logic [2:0] CLOCK_DIV1024 = 3'h7;

  typedef enum logic [1:0] {
    mode_normal,
    mode_phase_pwm,
    mode_clear_on_match,
    mode_fast_pwm
  } wave_mode_t;

  typedef enum logic [1:0] {
    act_none,
    act_toggle,
    act_clear,
    act_set
  } pin_action_t;

endpackage : timer2_pkg

/* File: design/prescale_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface prescale_if;
  logic [2:0] clock_select;
  logic tick;
  modport timer (output clock_select, input tick);
  modport prescaler (input clock_select, output tick);
endinterface : prescale_if
`default_nettype wire

/* File: design/timer2_prescaler.sv */
`timescale 1ns/1ps
`default_nettype none
module timer2_prescaler #(
  parameter int WIDTH = timer2_pkg::PRESCALE_WIDTH
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // select in, tick out
  prescale_if.prescaler pif
);

  typedef struct packed {
    logic [WIDTH-1:0] count;
    logic tick;
  } pre_state_t;

  pre_state_t state_q;
  pre_state_t state_d;

  function automatic logic low_ones(input logic [WIDTH-1:0] c,
                                    input int n);
    logic r;
    r = 1'b1;
    for (int i = 0; i < WIDTH; i++) begin
      if (i < n && !c[i]) begin
        r = 1'b0;
      end
    end
    return r;
  endfunction : low_ones

  always_comb begin
    state_d = state_q;
    state_d.count = state_q.count + {{(WIDTH-1){1'b0}}, 1'b1};
    case (pif.clock_select)
      timer2_pkg::CLOCK_STOPPED: state_d.tick = 1'b0;
      timer2_pkg::CLOCK_DIV1: state_d.tick = 1'b1;
      timer2_pkg::CLOCK_DIV8:
        state_d.tick = low_ones(state_q.count, timer2_pkg::DIV8_LOG2);
      timer2_pkg::CLOCK_DIV32:
        state_d.tick = low_ones(state_q.count, timer2_pkg::DIV32_LOG2);
      timer2_pkg::CLOCK_DIV64:
        state_d.tick = low_ones(state_q.count, timer2_pkg::DIV64_LOG2);
      timer2_pkg::CLOCK_DIV128:
        state_d.tick = low_ones(state_q.count, timer2_pkg::DIV128_LOG2);
      timer2_pkg::CLOCK_DIV256:
        state_d.tick = low_ones(state_q.count, timer2_pkg::DIV256_LOG2);
      default:
        state_d.tick = low_ones(state_q.count, timer2_pkg::DIV1024_LOG2);
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign pif.tick = state_q.tick;

endmodule : timer2_prescaler
`default_nettype wire

/* File: design/timer2_waveform_control.sv */
`timescale 1ns/1ps
`default_nettype none
module timer2_waveform_control (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // i/o register port
  input wire logic [5:0] i_io_addr,
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  input wire logic [7:0] i_io_wdata,
  output logic [7:0] o_io_rdata,
  // port pin
  input wire logic i_pin_direction,
  output logic o_compare_output_pin,
  output logic o_pin_override,
  output logic o_pin_drive_en,
  // event pulses
  output logic o_overflow_flag,
  output logic o_compare_match
);

  typedef struct packed {
    logic wave_mode_low_bit;
    logic wave_mode_high_bit;
    logic [1:0] out_mode;
    logic [2:0] clock_select;
    logic [7:0] count;
    logic [7:0] compare_active;
    logic [7:0] compare_buffer;
    logic count_down;
    logic match_block;
    logic pin;
    logic override;
    logic drive_en;
    logic overflow;
    logic match;
    logic [7:0] rdata;
  } state_t;

  state_t state_q;
  state_t state_d;

  prescale_if pif ();

  timer2_prescaler #(
    .WIDTH(timer2_pkg::PRESCALE_WIDTH)
  ) u_prescaler (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .pif(pif)
  );

  assign pif.clock_select = state_q.clock_select;

  function automatic timer2_pkg::wave_mode_t decode_mode(input logic hi,
                                                         input logic lo);
    timer2_pkg::wave_mode_t m;
    case ({hi, lo})
      2'h0: m = timer2_pkg::mode_normal;
      2'h1: m = timer2_pkg::mode_phase_pwm;
      2'h2: m = timer2_pkg::mode_clear_on_match;
      default: m = timer2_pkg::mode_fast_pwm;
    endcase
    return m;
  endfunction : decode_mode

  function automatic logic is_pwm(input timer2_pkg::wave_mode_t m);
    return m == timer2_pkg::mode_phase_pwm || m == timer2_pkg::mode_fast_pwm;
  endfunction : is_pwm

  // action taken on a compare match; down only matters in phase pwm
  function automatic timer2_pkg::pin_action_t match_action(
      input timer2_pkg::wave_mode_t m, input logic [1:0] om,
      input logic down);
    timer2_pkg::pin_action_t a;
    a = timer2_pkg::act_none;
    if (!is_pwm(m)) begin
      case (om)
        2'h1: a = timer2_pkg::act_toggle;
        2'h2: a = timer2_pkg::act_clear;
        2'h3: a = timer2_pkg::act_set;
        default: a = timer2_pkg::act_none;
      endcase
    end else if (m == timer2_pkg::mode_fast_pwm) begin
      case (om)
        2'h2: a = timer2_pkg::act_clear;
        2'h3: a = timer2_pkg::act_set;
        default: a = timer2_pkg::act_none;
      endcase
    end else begin
      case (om)
        2'h2: a = down ? timer2_pkg::act_set : timer2_pkg::act_clear;
        2'h3: a = down ? timer2_pkg::act_clear : timer2_pkg::act_set;
        default: a = timer2_pkg::act_none;
      endcase
    end
    return a;
  endfunction : match_action

  function automatic logic apply_action(input timer2_pkg::pin_action_t a,
                                        input logic pin);
    logic r;
    case (a)
      timer2_pkg::act_toggle: r = ~pin;
      timer2_pkg::act_clear: r = 1'b0;
      timer2_pkg::act_set: r = 1'b1;
      default: r = pin;
    endcase
    return r;
  endfunction : apply_action

  timer2_pkg::wave_mode_t mode;
  timer2_pkg::wave_mode_t wr_mode;
  logic [7:0] top;
  logic hit;
  logic top_special;
  logic wr_ctrl;
  logic wr_count;
  logic wr_compare;

  always_comb begin
    mode = decode_mode(state_q.wave_mode_high_bit, state_q.wave_mode_low_bit);
    wr_mode = decode_mode(i_io_wdata[timer2_pkg::WAVE_MODE_HIGH_BIT],
                          i_io_wdata[timer2_pkg::WAVE_MODE_LOW_BIT]);
    wr_ctrl = i_io_wr && i_io_addr == timer2_pkg::TIMER_CONTROL_ADDR;
    wr_count = i_io_wr && i_io_addr == timer2_pkg::COUNTER_VALUE_ADDR;
    wr_compare = i_io_wr && i_io_addr == timer2_pkg::COMPARE_VALUE_ADDR;
    top = (mode == timer2_pkg::mode_clear_on_match) ?
          state_q.compare_active : timer2_pkg::COUNT_MAX;
    hit = (state_q.count == state_q.compare_active) &&
          !state_q.match_block;
    top_special = is_pwm(mode) && state_q.out_mode[1] &&
                  state_q.compare_active == timer2_pkg::COUNT_MAX;

    state_d = state_q;
    state_d.overflow = 1'b0;
    state_d.match = 1'b0;

    if (pif.tick) begin
      state_d.match_block = 1'b0;
      state_d.match = hit;
      if (hit && !top_special) begin
        state_d.pin = apply_action(
            match_action(mode, state_q.out_mode, state_q.count_down),
            state_q.pin);
      end
      case (mode)
        timer2_pkg::mode_normal: begin
          state_d.count = state_q.count + 8'h01;
          state_d.overflow = state_q.count == timer2_pkg::COUNT_MAX;
        end
        timer2_pkg::mode_clear_on_match: begin
          if (hit && state_q.count == top) begin
            state_d.count = timer2_pkg::COUNT_BOTTOM;
          end else begin
            state_d.count = state_q.count + 8'h01;
          end
          state_d.overflow = state_q.count == timer2_pkg::COUNT_MAX;
        end
        timer2_pkg::mode_fast_pwm: begin
          state_d.count = state_q.count + 8'h01;
          if (state_q.count == top) begin
            state_d.overflow = 1'b1;
            state_d.compare_active = state_q.compare_buffer;
            case (state_q.out_mode)
              2'h2: state_d.pin = 1'b1;
              2'h3: state_d.pin = 1'b0;
              default: state_d.pin = state_d.pin;
            endcase
          end
        end
        timer2_pkg::mode_phase_pwm: begin
          if (!state_q.count_down) begin
            if (state_q.count == top) begin
              state_d.count_down = 1'b1;
              state_d.count = state_q.count - 8'h01;
              state_d.compare_active = state_q.compare_buffer;
              if (top_special) begin
                state_d.pin = apply_action(
                    match_action(mode, state_q.out_mode, 1'b1),
                    state_q.pin);
              end
            end else begin
              state_d.count = state_q.count + 8'h01;
            end
          end else if (state_q.count == timer2_pkg::COUNT_BOTTOM) begin
            state_d.count_down = 1'b0;
            state_d.count = state_q.count + 8'h01;
            state_d.overflow = 1'b1;
          end else begin
            state_d.count = state_q.count - 8'h01;
          end
        end
        default: state_d.count = state_q.count;
      endcase
    end

    // software writes win over counting in the same cycle
    if (wr_count) begin
      state_d.count = i_io_wdata;
      state_d.match_block = 1'b1;
    end
    if (wr_compare) begin
      state_d.compare_buffer = i_io_wdata;
      if (!is_pwm(mode)) begin
        state_d.compare_active = i_io_wdata;
      end
    end
    if (wr_ctrl) begin
      state_d.wave_mode_low_bit = i_io_wdata[timer2_pkg::WAVE_MODE_LOW_BIT];
      state_d.wave_mode_high_bit = i_io_wdata[timer2_pkg::WAVE_MODE_HIGH_BIT];
      state_d.out_mode = i_io_wdata[timer2_pkg::OUT_MODE_HIGH_BIT:
                                    timer2_pkg::OUT_MODE_LOW_BIT];
      state_d.clock_select = i_io_wdata[timer2_pkg::CLOCK_SELECT_MSB:
                                        timer2_pkg::CLOCK_SELECT_LSB];
      // strobe only: no flag, no counter clear
      if (i_io_wdata[timer2_pkg::FORCE_COMPARE_BIT] &&
          !is_pwm(wr_mode)) begin
        state_d.pin = apply_action(
            match_action(wr_mode,
                         i_io_wdata[timer2_pkg::OUT_MODE_HIGH_BIT:
                                    timer2_pkg::OUT_MODE_LOW_BIT],
                         1'b0),
            state_d.pin);
      end
    end

    state_d.override = state_d.out_mode != 2'h0;
    state_d.drive_en = state_d.override && i_pin_direction;

    if (i_io_rd) begin
      case (i_io_addr)
        timer2_pkg::TIMER_CONTROL_ADDR:
          state_d.rdata = {1'b0, state_q.wave_mode_low_bit, state_q.out_mode,
                           state_q.wave_mode_high_bit,
                           state_q.clock_select};
        timer2_pkg::COUNTER_VALUE_ADDR: state_d.rdata = state_q.count;
        timer2_pkg::COMPARE_VALUE_ADDR: state_d.rdata = state_q.compare_buffer;
        default: state_d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state_q <= '0;
      state_q.count <= timer2_pkg::COUNTER_VALUE_RESET;
      state_q.compare_active <= timer2_pkg::COMPARE_VALUE_RESET;
      state_q.compare_buffer <= timer2_pkg::COMPARE_VALUE_RESET;
      state_q.clock_select <=
          timer2_pkg::TIMER_CONTROL_RESET[timer2_pkg::CLOCK_SELECT_MSB:
                                          timer2_pkg::CLOCK_SELECT_LSB];
    end else begin
      state_q <= state_d;
    end
  end

  assign o_io_rdata = state_q.rdata;
  assign o_compare_output_pin = state_q.pin;
  assign o_pin_override = state_q.override;
  assign o_pin_drive_en = state_q.drive_en;
  assign o_overflow_flag = state_q.overflow;
  assign o_compare_match = state_q.match;

endmodule : timer2_waveform_control
`default_nettype wire

/* File: testbench/timer2_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module timer2_checker (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // i/o register port
  input wire logic [5:0] i_io_addr,
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  input wire logic [7:0] i_io_wdata,
  input wire logic [7:0] o_io_rdata,
  // port pin
  input wire logic i_pin_direction,
  input wire logic o_compare_output_pin,
  input wire logic o_pin_override,
  input wire logic o_pin_drive_en,
  // event pulses
  input wire logic o_overflow_flag,
  input wire logic o_compare_match
);
  logic [7:0] ctl_q;
  logic [7:0] cmp_q;
  logic [2:0] stop_q;
  logic ctl_wr;
  logic quiet_force;
  assign ctl_wr = i_io_wr && i_io_addr == timer2_pkg::TIMER_CONTROL_ADDR;
  // force write while the timer has been stopped for a while
  assign quiet_force = ctl_wr && i_io_wdata[7] && i_io_wdata[2:0] == 3'h0
    && stop_q >= 3'h4;
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      ctl_q <= 8'h00;
      cmp_q <= 8'h00;
      stop_q <= 3'h0;
    end else begin
      if (ctl_wr)
        ctl_q <= i_io_wdata;
      if (i_io_wr && i_io_addr == timer2_pkg::COMPARE_VALUE_ADDR)
        cmp_q <= i_io_wdata;
      if (ctl_q[2:0] != 3'h0)
        stop_q <= 3'h0;
      else if (stop_q != 3'h7)
        stop_q <= stop_q + 3'h1;
    end
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  chk_ctl_readback: assert property (
    i_io_rd && i_io_addr == timer2_pkg::TIMER_CONTROL_ADDR
    |=> o_io_rdata == {1'b0, $past(ctl_q[6:0])})
    else $error("control readback wrong");
  chk_cmp_readback: assert property (
    i_io_rd && i_io_addr == timer2_pkg::COMPARE_VALUE_ADDR
    |=> o_io_rdata == $past(cmp_q))
    else $error("compare readback wrong");
  chk_pin_override: assert property (
    ctl_wr |=> o_pin_override == $past(i_io_wdata[5] | i_io_wdata[4]))
    else $error("override does not follow output mode");
  chk_drive_direction: assert property (
    o_pin_drive_en |-> $past(i_pin_direction))
    else $error("pin driven without output direction");
  chk_reset_idle: assert property (
    $fell(i_rst) |-> !o_pin_override && !o_compare_output_pin
    && o_io_rdata == 8'h00)
    else $error("outputs not idle after reset");
  chk_stopped_quiet: assert property (
    stop_q == 3'h7 |-> !o_overflow_flag && !o_compare_match)
    else $error("event while clock stopped");
  chk_force_action: assert property (
    quiet_force && !i_io_wdata[6] && (i_io_wdata[5] | i_io_wdata[4])
    |=> o_compare_output_pin == ($past(i_io_wdata[5:4]) == 2'h1 ?
    !$past(o_compare_output_pin) : $past(i_io_wdata[4])))
    else $error("forced compare action wrong");
  chk_force_no_match: assert property (
    quiet_force |=> !o_compare_match [*2])
    else $error("forced compare gave a match pulse");
  chk_force_pwm_off: assert property (
    quiet_force && i_io_wdata[6] |=> $stable(o_compare_output_pin))
    else $error("forced compare acted in pwm mode");
  chk_overflow_pulse: assert property (
    o_overflow_flag |=> !o_overflow_flag)
    else $error("overflow pulse too long");
endmodule : timer2_checker
bind timer2_waveform_control timer2_checker timer2_checker_i (
  .i_clock(i_clock), .i_rst(i_rst), .i_io_addr(i_io_addr),
  .i_io_wr(i_io_wr), .i_io_rd(i_io_rd), .i_io_wdata(i_io_wdata),
  .o_io_rdata(o_io_rdata), .i_pin_direction(i_pin_direction),
  .o_compare_output_pin(o_compare_output_pin),
  .o_pin_override(o_pin_override), .o_pin_drive_en(o_pin_drive_en),
  .o_overflow_flag(o_overflow_flag), .o_compare_match(o_compare_match));
`default_nettype wire

/* File: testbench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [5:0] CMP = timer2_pkg::COMPARE_VALUE_ADDR;
  localparam logic [5:0] CNT = timer2_pkg::COUNTER_VALUE_ADDR;
  localparam logic [5:0] CTL = timer2_pkg::TIMER_CONTROL_ADDR;
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic [5:0] i_io_addr = 6'h00;
  logic i_io_wr = 1'b0;
  logic i_io_rd = 1'b0;
  logic [7:0] i_io_wdata = 8'h00;
  logic i_pin_direction = 1'b0;
  logic [7:0] o_io_rdata;
  logic o_compare_output_pin, o_pin_override, o_pin_drive_en;
  logic o_overflow_flag, o_compare_match;
  logic rd_seen = 1'b0;
  logic pv;
  logic [7:0] exp_q[$];
  int num_errors = 0;
  int n_tests = 0;
  int n_match = 0;
  int n, c;
  int divs[8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
  // control value, expected pin after the forced compare
  logic [8:0] ftab[8] = '{9'h161, 9'h140, 9'h121, 9'h120, 9'h171, 9'h150,
    9'h1e0, 9'h1f0};

  timer2_waveform_control timer2_waveform_control_i (
    .i_clock(i_clock), .i_rst(i_rst), .i_io_addr(i_io_addr),
    .i_io_wr(i_io_wr), .i_io_rd(i_io_rd), .i_io_wdata(i_io_wdata),
    .o_io_rdata(o_io_rdata), .i_pin_direction(i_pin_direction),
    .o_compare_output_pin(o_compare_output_pin),
    .o_pin_override(o_pin_override), .o_pin_drive_en(o_pin_drive_en),
    .o_overflow_flag(o_overflow_flag), .o_compare_match(o_compare_match));

  always #2 i_clock = ~i_clock;

  task automatic report(input bit ok, input logic [31:0] got, exp);
    n_tests++;
    if (!ok) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : report
  task automatic check_rd(input logic [7:0] got, exp);
    report(got === exp, 32'(got), 32'(exp));
  endtask : check_rd
  task automatic check_pin(input logic got, exp);
    report(got === exp, 32'(got), 32'(exp));
  endtask : check_pin
  task automatic check_num(input int got, exp);
    report(got == exp, got, exp);
  endtask : check_num

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge i_clock);
    i_io_addr = a;
    i_io_wdata = d;
    i_io_wr = 1'b1;
    @(negedge i_clock);
    i_io_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    @(negedge i_clock);
    exp_q.push_back(e);
    i_io_addr = a;
    i_io_rd = 1'b1;
    @(negedge i_clock);
    i_io_rd = 1'b0;
  endtask : rd
  task automatic next_pulse(input bit m, input int lim, output int k);
    k = 0;
    do begin
      @(negedge i_clock);
      k++;
    end while ((m ? o_compare_match : o_overflow_flag) !== 1'b1 && k < lim);
  endtask : next_pulse
  task automatic pwm_case(input logic [7:0] ctl, input int cv, per, hi);
    int k;
    int h;
    wr(CTL, 8'h00);
    wr(CMP, cv[7:0]);
    wr(CTL, ctl);
    repeat (3) next_pulse(0, 3000, k);
    check_num(k, per);
    h = 0;
    repeat (per) begin
      @(negedge i_clock);
      h += (o_compare_output_pin === 1'b1);
    end
    check_num(h, hi);
  endtask : pwm_case
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict

  // read results taken half a cycle after the read edge
  always @(posedge i_clock) rd_seen <= i_io_rd;
  always @(negedge i_clock) begin
    if (rd_seen)
      check_rd(o_io_rdata, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);
    if (o_compare_match === 1'b1)
      n_match++;
  end

  initial begin
    #200000;
    num_errors++;
    print_verdict();
  end

  initial begin
    void'($urandom(32'he5e5));
    repeat (16) @(negedge i_clock);
    i_rst = 1'b0;
    rd(CTL, 8'h00);
    rd(CMP, 8'h00);
    rd(CNT, 8'h00);
    rd(6'h3f, 8'h00);
    check_pin(o_pin_override, 1'b0);
    $display("reset test done");
    repeat (4) begin
      c = $urandom;
      wr(CMP, c[7:0]);
      rd(CMP, c[7:0]);
      // strobe only while the written mode is non-pwm
      wr(CTL, {!c[14], c[14:11], 3'h0});
      rd(CTL, {1'b0, c[14:11], 3'h0});
    end
    $display("readback test done");
    c = $urandom;
    for (int i = 0; i < 8; i++) begin
      i_pin_direction = c[i];
      n = n_match;
      wr(CTL, ftab[i][8:1]);
      @(negedge i_clock);
      check_pin(o_compare_output_pin, ftab[i][0]);
      check_pin(o_pin_drive_en, i_pin_direction);
      check_num(n_match, n);
    end
    $display("force test done");
    c = 3 + $urandom % 20;
    // leave pwm first so the compare value loads at once
    wr(CTL, 8'h00);
    wr(CMP, c[7:0]);
    wr(CNT, 8'h00);
    wr(CTL, 8'h19);
    repeat (2) next_pulse(1, 300, n);
    check_num(n, c + 1);
    pv = o_compare_output_pin;
    next_pulse(1, 300, n);
    check_pin(o_compare_output_pin, !pv);
    wr(CNT, c[7:0]);
    next_pulse(1, 600, n);
    check_num(int'(n > 250), 1);
    $display("clear on match test done");
    wr(CMP, 8'h01);
    for (int s = 1; s < 8; s++) begin
      wr(CTL, {5'h01, 3'(s)});
      repeat (2) next_pulse(1, 3000, n);
      check_num(n, 2 * divs[s]);
    end
    wr(CTL, 8'h08);
    repeat (4) @(negedge i_clock);
    next_pulse(1, 600, n);
    check_num(n, 600);
    $display("clock select test done");
    c = 1 + $urandom % 254;
    pwm_case(8'h69, c, 256, c + 1);
    pwm_case(8'h79, c, 256, 255 - c);
    pwm_case(8'h69, 255, 256, 256);
    pwm_case(8'h79, 255, 256, 0);
    pwm_case(8'h61, c, 510, 2 * c);
    pwm_case(8'h71, c, 510, 510 - 2 * c);
    pwm_case(8'h61, 255, 510, 510);
    pwm_case(8'h71, 255, 510, 0);
    $display("pwm test done");
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
